// ---- scvs_cmd_rx.v ----
// Serial command frame receiver sampled on detected SDCLK rising edges
`timescale 1ns/1ps
`default_nettype none
`include "scvs_defines.vh"
module scvs_cmd_rx (
  // System
  input wire clk_i,
  input wire rst_i,
  // Sampled link
  input wire en_i,
  input wire rise_i,
  input wire cmd_i,
  // Decoded frame
  output wire vld_o,
  output wire [5:0] idx_o,
  output wire [31:0] arg_o
);
  reg [46:0] sh_ff;
  reg [5:0] cnt_ff;
  reg busy_ff;
  reg vld_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sh_ff <= 47'h0;
      cnt_ff <= 6'h0;
      busy_ff <= 1'b0;
      vld_ff <= 1'b0;
    end else begin
      vld_ff <= 1'b0;
      if (!en_i) begin
        busy_ff <= 1'b0;
        cnt_ff <= 6'h0;
      end else if (rise_i) begin
        if (!busy_ff) begin
          // Start bit
          if (!cmd_i) begin
            busy_ff <= 1'b1;
            cnt_ff <= `SCVS_RX_BITS;
          end
        end else begin
          sh_ff <= {sh_ff[45:0], cmd_i};
          cnt_ff <= cnt_ff - 6'h1;
          if (cnt_ff == 6'h1) begin
            busy_ff <= 1'b0;
            // Needs host direction bit and end bit
            vld_ff <= cmd_i & sh_ff[45];
          end
        end
      end
    end
  end

  assign vld_o = vld_ff;
  assign idx_o = sh_ff[45:40];
  assign arg_o = sh_ff[39:8];
endmodule // scvs_cmd_rx
`default_nettype wire

// ---- scvs_defines.vh ----
// Constants for the card-side init and signal voltage switch block
`ifndef SCVS_DEFINES_VH
`define SCVS_DEFINES_VH

// Register offsets (byte addresses)
`define SCVS_ADR_CTRL 8'h00
`define SCVS_ADR_STAT 8'h04
`define SCVS_ADR_ARG 8'h08

// Control register fields and reset value
`define SCVS_CTRL_SUP18 0
`define SCVS_CTRL_CCS 1
`define SCVS_CTRL_DONE 2
`define SCVS_CTRL_RST 3'h1

// Argument and response fields
`define SCVS_ARG_HCS 30
`define SCVS_ARG_XPC 28
`define SCVS_ARG_S18R 24
`define SCVS_OCR_VDD 24'hFF_8000

// Command indices
`define SCVS_IDX_RESET 6'h00
`define SCVS_IDX_VSW 6'h0B
`define SCVS_IDX_OPCOND 6'h29
`define SCVS_IDX_APP 6'h37

// Frame sizes and SDCLK edge counts
`define SCVS_FRAME_BITS 6'h30
`define SCVS_RX_BITS 6'h2F
`define SCVS_NCR_EDGES 2'h2
`define SCVS_HIGH_EDGES 2'h2

// Timing: clock rate and times in their own units
`define SCVS_CLK_MHZ 200
`define SCVS_T_SETTLE_US 5000
`define SCVS_T_WINDOW_US 1000
`define SCVS_T_STOP_NS 6000
// Cycle counts of the times above, sized to the counters that use them
`define SCVS_SETTLE_CYC 21'h0F_4240
`define SCVS_WINDOW_CYC 21'h03_0D40
`define SCVS_STOP_CYC 11'h4B0

`endif

// ---- scvs_host_model.sv ----
// Behavioural SD host: link clock, command frames and response capture
`timescale 1ns/1ps
`default_nettype none
module scvs_host_model (
  // Resolved CMD level
  input wire logic cmd_i,
  // Host drive
  output logic sdclk_o,
  output logic cmd_o,
  output logic cmd_oe_o
);
  initial begin
    sdclk_o = 1'b0;
    cmd_o = 1'b1;
    cmd_oe_o = 1'b0;
  end
  // Clock toggles only inside tasks, so it rests low between them
  task automatic ticks(input int n);
    repeat (n) begin
      #24 sdclk_o = 1'b1;
      #24 sdclk_o = 1'b0;
    end
  endtask
  // Bits change while the clock is low, MSB first
  task automatic send(input logic [5:0] idx, input logic [31:0] arg);
    logic [47:0] f;
    f = {2'b01, idx, arg, 7'h00, 1'b1};
    cmd_oe_o = 1'b1;
    for (int i = 47; i >= 0; i--) begin
      cmd_o = f[i];
      ticks(1);
    end
    cmd_oe_o = 1'b0;
  endtask
  // Wait a bounded time for a start bit, then take 47 more bits
  task automatic get(output logic [47:0] r, output logic got);
    int n;
    r = 48'hffff_ffff_ffff;
    got = 1'b0;
    n = 0;
    while (!got && n < 64) begin
      #24 sdclk_o = 1'b1;
      got = (cmd_i === 1'b0);
      #24 sdclk_o = 1'b0;
      n++;
    end
    r[47] = ~got;
    for (int i = 46; i >= 0 && got; i--) begin
      #24 sdclk_o = 1'b1;
      r[i] = cmd_i;
      #24 sdclk_o = 1'b0;
    end
  endtask
endmodule // scvs_host_model
`default_nettype wire

// ---- scvs_top.v ----
// Card-side init command handling and signal voltage switch sequence
`timescale 1ns/1ps
`default_nettype none
`include "scvs_defines.vh"
module scvs_top #(
  parameter [20:0] SETTLE_CYC = `SCVS_SETTLE_CYC,
  parameter [20:0] WINDOW_CYC = `SCVS_WINDOW_CYC
) (
  // System
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // SD bus pins
  input wire sdclk_i,
  input wire cmd_i,
  output wire cmd_o,
  output wire cmd_oe_o,
  input wire [3:0] dat_i,
  output wire [3:0] dat_o,
  output wire [3:0] dat_oe_o,
  // Regulator
  input wire volt_err_i,
  output wire reg_sel_18v_o,
  output wire sig18_o,
  output wire xpc_o
);
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_SWLOW = 6'b000010;
  localparam [5:0] ST_REGSW = 6'b000100;
  localparam [5:0] ST_DRVHI = 6'b001000;
  localparam [5:0] ST_ERR = 6'b010000;
  localparam [5:0] ST_DONE = 6'b100000;
  localparam [10:0] STOP_CYC = `SCVS_STOP_CYC;

  // CRC7 over a 40-bit response head
  function [6:0] scvs_crc7;
    input [39:0] d;
    integer i;
    reg [6:0] c;
    reg fb;
    begin
      c = 7'h00;
      for (i = 39; i >= 0; i = i - 1) begin
        fb = d[i] ^ c[6];
        c = {c[5:0], 1'b0};
        if (fb) begin
          c = c ^ 7'h09;
        end
      end
      scvs_crc7 = c;
    end
  endfunction

  // Card status word with current state and app flag
  function [31:0] scvs_status;
    input rdy;
    input app;
    begin
      scvs_status = {19'h0, 3'h0, rdy, 1'b0, 2'h0, app, 5'h0};
    end
  endfunction

  // Synchronisers
  reg sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  reg cmd_s1_ff, cmd_s2_ff;
  reg [3:0] dat_s1_ff, dat_s2_ff;
  reg err_s1_ff, err_s2_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      cmd_s1_ff <= 1'b1;
      cmd_s2_ff <= 1'b1;
      dat_s1_ff <= 4'h0;
      dat_s2_ff <= 4'h0;
      err_s1_ff <= 1'b0;
      err_s2_ff <= 1'b0;
    end else begin
      sclk_s1_ff <= sdclk_i;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      cmd_s1_ff <= cmd_i;
      cmd_s2_ff <= cmd_s1_ff;
      dat_s1_ff <= dat_i;
      dat_s2_ff <= dat_s1_ff;
      err_s1_ff <= volt_err_i;
      err_s2_ff <= err_s1_ff;
    end
  end

  wire rise = sclk_s2_ff & ~sclk_s3_ff;
  wire fall = ~sclk_s2_ff & sclk_s3_ff;

  // Card state
  reg [5:0] st_ff;
  reg [2:0] ctrl_ff;
  reg init_ff, ready_ff, hcs_ff, xpc_ff, s18r_ff, accept_ff, app_ff;
  reg [31:0] arg1_ff;
  reg sig18_ff, reg_sel_ff;
  reg cmd_ff, cmd_oe_ff;
  reg [3:0] dat_ff, dat_oe_ff;
  reg [47:0] tx_sh_ff;
  reg [5:0] tx_bits_ff;
  reg [1:0] tx_wait_ff;
  reg tx_busy_ff, tx_sw_ff;
  reg [20:0] tmr_ff, win_ff;
  reg settled_ff, restart_ff;
  reg [1:0] hi_cnt_ff;

  // Command receiver
  wire rx_vld;
  wire [5:0] rx_idx;
  wire [31:0] rx_arg;

  scvs_cmd_rx u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(st_ff[0] & ~tx_busy_ff),
    .rise_i(rise),
    .cmd_i(cmd_s2_ff),
    .vld_o(rx_vld),
    .idx_o(rx_idx),
    .arg_o(rx_arg)
  );

  wire is_cmd0 = rx_vld & (rx_idx == `SCVS_IDX_RESET);
  wire is_cmd55 = rx_vld & (rx_idx == `SCVS_IDX_APP);
  wire is_acmd41 = rx_vld & app_ff & (rx_idx == `SCVS_IDX_OPCOND);
  wire is_cmd11 = rx_vld & ~app_ff & (rx_idx == `SCVS_IDX_VSW);
  wire win_zero = (rx_arg[23:0] == 24'h0);
  wire nxt_ready = init_ff & ctrl_ff[`SCVS_CTRL_DONE] &
    (hcs_ff | ~ctrl_ff[`SCVS_CTRL_CCS]);
  // S18A only from 3.3V, on request, with support
  wire s18a = ~sig18_ff & s18r_ff & ctrl_ff[`SCVS_CTRL_SUP18];
  // Flags beyond the voltage window are zero while busy
  wire [31:0] ocr = {ready_ff, ready_ff & ctrl_ff[`SCVS_CTRL_CCS], 5'h0,
    ready_ff & s18a, `SCVS_OCR_VDD};
  wire sw_ok = accept_ff & ready_ff & ~sig18_ff;
  wire [31:0] r1_stat = scvs_status(ready_ff, is_cmd55);
  wire [39:0] r1_head = {2'b00, rx_idx, r1_stat};

  always @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      init_ff <= 1'b0;
      ready_ff <= 1'b0;
      hcs_ff <= 1'b0;
      xpc_ff <= 1'b0;
      s18r_ff <= 1'b0;
      accept_ff <= 1'b0;
      app_ff <= 1'b0;
      arg1_ff <= 32'h0000_0000;
      sig18_ff <= 1'b0;
      reg_sel_ff <= 1'b0;
      cmd_ff <= 1'b1;
      cmd_oe_ff <= 1'b0;
      dat_ff <= 4'h0;
      dat_oe_ff <= 4'h0;
      tx_sh_ff <= 48'h0000_0000_0000;
      tx_bits_ff <= 6'h0;
      tx_wait_ff <= 2'h0;
      tx_busy_ff <= 1'b0;
      tx_sw_ff <= 1'b0;
      tmr_ff <= 21'h0;
      win_ff <= 21'h0;
      settled_ff <= 1'b0;
      restart_ff <= 1'b0;
      hi_cnt_ff <= 2'h0;
    end else begin
      ready_ff <= nxt_ready;
      if (rx_vld) begin
        app_ff <= is_cmd55;
      end
      // Command decode and response load
      if (is_cmd0) begin
        init_ff <= 1'b0;
        ready_ff <= 1'b0;
        accept_ff <= 1'b0;
      end else if (is_cmd55) begin
        tx_sh_ff <= {r1_head, scvs_crc7(r1_head), 1'b1};
        tx_bits_ff <= `SCVS_FRAME_BITS;
        tx_wait_ff <= `SCVS_NCR_EDGES;
        tx_busy_ff <= 1'b1;
        tx_sw_ff <= 1'b0;
      end else if (is_acmd41) begin
        if (!win_zero && !init_ff) begin
          // First initializing request latches the upper field
          init_ff <= 1'b1;
          arg1_ff <= rx_arg;
          hcs_ff <= rx_arg[`SCVS_ARG_HCS];
          xpc_ff <= rx_arg[`SCVS_ARG_XPC];
          s18r_ff <= rx_arg[`SCVS_ARG_S18R];
        end
        // Inquiry leaves all latched fields alone
        if (!win_zero && ready_ff && s18a) begin
          accept_ff <= 1'b1;
        end
        tx_sh_ff <= {2'b00, 6'h3F, ocr, 7'h7F, 1'b1};
        tx_bits_ff <= `SCVS_FRAME_BITS;
        tx_wait_ff <= `SCVS_NCR_EDGES;
        tx_busy_ff <= 1'b1;
        tx_sw_ff <= 1'b0;
      end else if (is_cmd11 && sw_ok) begin
        tx_sh_ff <= {r1_head, scvs_crc7(r1_head), 1'b1};
        tx_bits_ff <= `SCVS_FRAME_BITS;
        tx_wait_ff <= `SCVS_NCR_EDGES;
        tx_busy_ff <= 1'b1;
        tx_sw_ff <= 1'b1;
      end
      // Response shifter: outputs change after falling SDCLK edges
      if (tx_busy_ff) begin
        if (tx_wait_ff != 2'h0) begin
          if (rise) begin
            tx_wait_ff <= tx_wait_ff - 2'h1;
          end
        end else if (fall) begin
          if (tx_bits_ff != 6'h0) begin
            cmd_ff <= tx_sh_ff[47];
            cmd_oe_ff <= 1'b1;
            tx_sh_ff <= {tx_sh_ff[46:0], 1'b0};
            tx_bits_ff <= tx_bits_ff - 6'h1;
          end else begin
            tx_busy_ff <= 1'b0;
            if (tx_sw_ff) begin
              // Clock after the end bit: pull every line low
              cmd_ff <= 1'b0;
              dat_ff <= 4'h0;
              dat_oe_ff <= 4'hF;
              tmr_ff <= 21'h0;
              st_ff <= ST_SWLOW;
            end else begin
              cmd_ff <= 1'b1;
              cmd_oe_ff <= 1'b0;
            end
          end
        end
      end
      // Switch sequence
      case (st_ff)
        ST_IDLE: begin
        end
        ST_DONE: begin
        end
        ST_SWLOW: begin
          // A stop is a low longer than any half period at 100 kHz
          if (sclk_s2_ff) begin
            tmr_ff <= 21'h0;
          end else if (tmr_ff == {10'h0, STOP_CYC} - 21'h1) begin
            tmr_ff <= 21'h0;
            reg_sel_ff <= 1'b1;
            settled_ff <= 1'b0;
            restart_ff <= 1'b0;
            win_ff <= 21'h0;
            st_ff <= ST_REGSW;
          end else begin
            tmr_ff <= tmr_ff + 21'h1;
          end
        end
        ST_REGSW: begin
          // Local timer, SDCLK is stopped here
          if (!settled_ff) begin
            if (tmr_ff == SETTLE_CYC - 21'h1) begin
              settled_ff <= 1'b1;
              sig18_ff <= 1'b1;
            end else begin
              tmr_ff <= tmr_ff + 21'h1;
            end
          end
          if (rise) begin
            restart_ff <= 1'b1;
          end
          if (restart_ff) begin
            win_ff <= win_ff + 21'h1;
          end
          if (err_s2_ff) begin
            cmd_oe_ff <= 1'b0;
            dat_ff <= 4'h0;
            dat_oe_ff <= 4'hF;
            st_ff <= ST_ERR;
          end else if (settled_ff && (restart_ff || rise)) begin
            cmd_ff <= 1'b1;
            dat_ff <= 4'hF;
            hi_cnt_ff <= 2'h0;
            st_ff <= ST_DRVHI;
          end
        end
        ST_DRVHI: begin
          win_ff <= win_ff + 21'h1;
          if (rise) begin
            hi_cnt_ff <= hi_cnt_ff + 2'h1;
          end
          if (err_s2_ff) begin
            cmd_oe_ff <= 1'b0;
            dat_ff <= 4'h0;
            dat_oe_ff <= 4'hF;
            st_ff <= ST_ERR;
          end else if ((rise && hi_cnt_ff == `SCVS_HIGH_EDGES - 2'h1) ||
                       (win_ff >= WINDOW_CYC - 21'h1)) begin
            // Full SDCLK period high, and never past the window
            cmd_oe_ff <= 1'b0;
            dat_oe_ff <= 4'h0;
            accept_ff <= 1'b0;
            st_ff <= ST_DONE;
          end
        end
        ST_ERR: begin
          // Held until power is removed
          cmd_oe_ff <= 1'b0;
          dat_ff <= 4'h0;
          dat_oe_ff <= 4'hF;
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
      if (st_ff == ST_DONE) begin
        st_ff <= ST_IDLE;
      end
    end
  end

  // Wishbone slave
  reg wb_ack_ff;
  reg [31:0] wb_dat_ff;
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
  wire [31:0] stat_word = {11'h0, cmd_s2_ff, dat_s2_ff, err_s2_ff & 1'b0,
    st_ff == ST_ERR, accept_ff, s18r_ff, xpc_ff, hcs_ff, ready_ff, init_ff,
    sig18_ff, reg_sel_ff, st_ff};

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
      ctrl_ff <= `SCVS_CTRL_RST;
    end else begin
      wb_ack_ff <= wb_req;
      if (wb_req && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == `SCVS_ADR_CTRL) begin
        ctrl_ff <= wb_dat_i[2:0];
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `SCVS_ADR_CTRL: wb_dat_ff <= {29'h0, ctrl_ff};
          `SCVS_ADR_STAT: wb_dat_ff <= stat_word;
          `SCVS_ADR_ARG: wb_dat_ff <= arg1_ff;
          default: wb_dat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign cmd_o = cmd_ff;
  assign cmd_oe_o = cmd_oe_ff;
  assign dat_o = dat_ff;
  assign dat_oe_o = dat_oe_ff;
  assign reg_sel_18v_o = reg_sel_ff;
  assign sig18_o = sig18_ff;
  assign xpc_o = xpc_ff;
endmodule // scvs_top
`default_nettype wire

// ---- scvs_top_props.sv ----
// Port assertions for the card-side voltage switch block
`timescale 1ns/1ps
`default_nettype none
module scvs_top_props #(
  parameter [20:0] SETTLE_CYC = 21'd200,
  parameter [20:0] WINDOW_CYC = 21'd400
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // SD bus and regulator
  input wire logic sdclk_i,
  input wire logic cmd_o,
  input wire logic cmd_oe_o,
  input wire logic [3:0] dat_o,
  input wire logic [3:0] dat_oe_o,
  input wire logic reg_sel_18v_o,
  input wire logic sig18_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic low_drv, hi_drv, err_drv;
  logic [21:0] set_cnt_ff, win_cnt_ff;
  assign low_drv = cmd_oe_o && !cmd_o && dat_oe_o == 4'hf && dat_o == 4'h0;
  assign hi_drv = cmd_oe_o && cmd_o && dat_oe_o == 4'hf && dat_o == 4'hf;
  assign err_drv = !cmd_oe_o && dat_oe_o == 4'hf && dat_o == 4'h0;
  // Length of the settling phase and of the drive-high phase
  always @(posedge clk_i) begin
    set_cnt_ff <= (rst_i || !(reg_sel_18v_o && !sig18_o && low_drv)) ?
      22'h0 : set_cnt_ff + 22'h1;
  end
  always @(posedge clk_i) begin
    win_cnt_ff <= (rst_i || !hi_drv) ? 22'h0 : win_cnt_ff + 22'h1;
  end
  chk_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
  chk_low_entry: assert property (
    $rose(reg_sel_18v_o) |-> low_drv && !sdclk_i)
    else $error("regulator switched without lines low");
  chk_sig_after_sel: assert property (
    $rose(sig18_o) |-> reg_sel_18v_o && low_drv)
    else $error("signal level changed outside settling");
  chk_settle_max: assert property (
    set_cnt_ff <= {1'b0, SETTLE_CYC} + 22'h2)
    else $error("regulator settling too long");
  chk_high_min: assert property (
    $rose(hi_drv) |-> hi_drv [*8]) else $error("drive high too short");
  chk_window_max: assert property (
    win_cnt_ff <= {1'b0, WINDOW_CYC} + 22'h2)
    else $error("lines not released in window");
  chk_cmd_release: assert property (
    $fell(cmd_oe_o) |-> $past(cmd_o) || err_drv)
    else $error("CMD released from low level");
  chk_dat_release: assert property (
    $fell(dat_oe_o[0]) |-> $past(dat_o) == 4'hf && dat_oe_o == 4'h0)
    else $error("DAT released from low level");
  chk_err_hold: assert property (err_drv |=> err_drv)
    else $error("error indication dropped");
  chk_one_switch: assert property (
    $rose(dat_oe_o[0]) |-> !sig18_o) else $error("switch at 1.8V");
endmodule // scvs_top_props
bind scvs_top scvs_top_props #(
  .SETTLE_CYC(SETTLE_CYC),
  .WINDOW_CYC(WINDOW_CYC)
) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .sdclk_i(sdclk_i), .cmd_o(cmd_o),
  .cmd_oe_o(cmd_oe_o), .dat_o(dat_o), .dat_oe_o(dat_oe_o),
  .reg_sel_18v_o(reg_sel_18v_o), .sig18_o(sig18_o)
);
`default_nettype wire

// ---- scvs_top_tb.sv ----
// Self-checking bench for the card-side voltage switch block
`timescale 1ns/1ps
`default_nettype none
`include "scvs_defines.vh"
module scvs_top_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, dat_o, dat_oe_o, dat_w, sel_v;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic sdclk, cmd_o, cmd_oe_o, h_cmd, h_oe, cmd_w, volt_err_i;
  logic reg_sel_18v_o, sig18_o, xpc_o, got;
  logic [47:0] rsp;
  int error_cnt, total_checks, cyc_cnt;
  // Pull-ups on CMD and DAT decide released lines
  assign cmd_w = cmd_oe_o ? cmd_o : (h_oe ? h_cmd : 1'b1);
  assign dat_w = (dat_o & dat_oe_o) | ~dat_oe_o;
  scvs_top #(.SETTLE_CYC(21'd200), .WINDOW_CYC(21'd400)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sdclk_i(sdclk), .cmd_i(cmd_w), .cmd_o(cmd_o), .cmd_oe_o(cmd_oe_o),
    .dat_i(dat_w), .dat_o(dat_o), .dat_oe_o(dat_oe_o),
    .volt_err_i(volt_err_i), .reg_sel_18v_o(reg_sel_18v_o),
    .sig18_o(sig18_o), .xpc_o(xpc_o)
  );
  scvs_host_model host (
    .cmd_i(cmd_w), .sdclk_o(sdclk), .cmd_o(h_cmd), .cmd_oe_o(h_oe)
  );
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 80000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic cycle held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel_v;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  // Repeated application command pair; the last reply stays in rsp
  task automatic acmd(input logic [31:0] arg);
    repeat (2) begin
      host.send(`SCVS_IDX_APP, 32'h0000_0000);
      host.get(rsp, got);
      host.send(`SCVS_IDX_OPCOND, arg);
      host.get(rsp, got);
      host.ticks(4);
    end
  endtask
  task automatic cmd(input logic [5:0] idx);
    host.send(idx, 32'h0000_0000);
    host.get(rsp, got);
  endtask
  task automatic switch_entry();
    cmd(`SCVS_IDX_VSW);
    check(32'({got, rsp[45:40]}), 32'h0000_004b);
    wt(20);
    check(32'({cmd_w, dat_w}), 32'h0000_0000);
    wt(1300);
  endtask
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, volt_err_i} = 4'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'h0;
    sel_v = 4'hf;
    {error_cnt, total_checks, cyc_cnt} = '0;
    wt(3);
    rst_i <= 1'b0;
    sel_v = 4'he;
    wb(1'b1, `SCVS_ADR_CTRL, 32'h0000_0006);
    sel_v = 4'hf;
    wb(1'b0, `SCVS_ADR_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    wb(1'b0, `SCVS_ADR_STAT, 32'h0000_0000);
    check(rd, 32'h001f_0001);
    wb(1'b0, 8'h0c, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'({cmd_oe_o, dat_oe_o, reg_sel_18v_o, sig18_o}), 32'h0);
    $display("reset test done");
    acmd(32'h5100_0000);
    check(rsp[39:8], 32'h00ff_8000);
    check(32'({rsp[47:40], rsp[7:0]}), 32'h0000_3fff);
    wb(1'b0, `SCVS_ADR_ARG, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'(xpc_o), 32'h0);
    $display("inquiry test done");
    wb(1'b1, `SCVS_ADR_CTRL, 32'h0000_0003);
    acmd(32'h5110_0000);
    check(rsp[39:8], 32'h00ff_8000);
    wb(1'b0, `SCVS_ADR_ARG, 32'h0000_0000);
    check(rd, 32'h5110_0000);
    check(32'(xpc_o), 32'h1);
    wb(1'b1, `SCVS_ADR_CTRL, 32'h0000_0007);
    acmd(32'h5110_0000);
    check(rsp[39:8], 32'hc1ff_8000);
    acmd(32'h5110_0000);
    check(rsp[39:8], 32'hc1ff_8000);
    check(32'(xpc_o), 32'h1);
    $display("init test done");
    cmd(`SCVS_IDX_RESET);
    wb(1'b1, `SCVS_ADR_CTRL, 32'h0000_0005);
    acmd(32'h4010_0000);
    check(rsp[39:8], 32'h80ff_8000);
    check(32'(xpc_o), 32'h0);
    cmd(`SCVS_IDX_VSW);
    check(32'(got), 32'h0);
    $display("no-switch test done");
    cmd(`SCVS_IDX_RESET);
    acmd(32'h5110_0000);
    check(rsp[39:8], 32'h81ff_8000);
    switch_entry();
    check(32'({reg_sel_18v_o, sig18_o}), 32'h2);
    wt(220);
    check(32'({sig18_o, cmd_w, dat_w}), 32'h20);
    host.ticks(1);
    wt(4);
    check(32'({cmd_oe_o, cmd_w, dat_oe_o, dat_w}), 32'h3ff);
    host.ticks(3);
    wt(4);
    check(32'({cmd_oe_o, dat_oe_o, dat_w}), 32'h00f);
    $display("switch test done");
    acmd(32'h5110_0000);
    check(rsp[39:8], 32'h80ff_8000);
    cmd(`SCVS_IDX_VSW);
    check(32'(got), 32'h0);
    $display("1.8V test done");
    wt(1);
    rst_i <= 1'b1;
    wt(3);
    rst_i <= 1'b0;
    wb(1'b1, `SCVS_ADR_CTRL, 32'h0000_0005);
    acmd(32'h5110_0000);
    switch_entry();
    volt_err_i <= 1'b1;
    wt(300);
    check(32'({cmd_oe_o, dat_oe_o, dat_w}), 32'h0f0);
    volt_err_i <= 1'b0;
    host.ticks(4);
    wt(20);
    check(32'({cmd_oe_o, dat_oe_o, dat_w}), 32'h0f0);
    $display("error test done");
    final_report();
  end
endmodule // scvs_top_tb
`default_nettype wire
